// *** ext_line_ctrl_pkg.sv ***
// Constants for the external line trigger front end: offsets, field layout and reset values.
//
// Contract
// R01 - A line's rising edge sets its pending flag only while its rising enable bit is one.
// R02 - A line's falling edge sets its pending flag only while its falling enable bit is one.
// R03 - Software keeps bit 25 and bits 31 to 27 of the trigger registers at their reset values.
// R04 - The falling enable register resets to all zeros.
// R05 - Writing one to a software trigger bit that reads zero sets the pending flag and holds the bit at one.
// R06 - A software triggered pending flag raises the interrupt only if both its masks pass it.
// R07 - A software trigger bit clears only when software writes one to the line's pending flag.
// R08 - An enabled edge on a line input sets that line's pending flag.
// R09 - A pending flag clears on a write of one to it or on a change of the line's edge polarity.
// R10 - An interrupt mask bit of one passes the line's interrupt request and zero blocks it.
// R11 - An event mask bit of one passes the line's event request and zero blocks it.
// R12 - With both enables set a line triggers on either edge.

package ext_line_ctrl_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_IRQ_UNMASK = 8'h00;
  localparam logic [7:0] OFS_EVT_UNMASK = 8'h04;
  localparam logic [7:0] OFS_RISE_SEL   = 8'h08;
  localparam logic [7:0] OFS_FALL_SEL   = 8'h0c;
  localparam logic [7:0] OFS_SW_TRIG    = 8'h10;
  localparam logic [7:0] OFS_PENDING    = 8'h14;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          NUM_LINES     = 27;
  localparam logic [31:0] LINE_MASK     = 32'h05ff_ffff;
  localparam logic [31:0] RST_IRQ_MASK  = 32'h0000_0000;
  localparam logic [31:0] RST_EVT_MASK  = 32'h0000_0000;
  localparam logic [31:0] RST_RISE_SEL  = 32'h0000_0000;
  localparam logic [31:0] RST_FALL_SEL  = 32'h0000_0000;
  localparam logic [31:0] RST_SW_TRIG   = 32'h0000_0000;
  localparam logic [31:0] RST_PENDING   = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;

endpackage : ext_line_ctrl_pkg

// *** ext_line_edge_trigger_cfg.sv ***
// Edge trigger front end of the external line controller with its APB register file.
`timescale 1ns/10ps
`default_nettype none

module ext_line_edge_trigger_cfg
  import ext_line_ctrl_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_LINES-1:0] ext_line_in,
  output logic      [NUM_LINES-1:0] evt_out,
  output logic      [NUM_LINES-1:0] line_pending_flags,
  output logic                      irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    // Three stage input synchroniser and the filtered line level.
    logic [31:0] sync1;
    logic [31:0] sync2;
    logic [31:0] sync3;
    logic [31:0] filt;
    // Software visible registers; reserved bits always hold zero.
    logic [31:0] irq_unmask_bits;
    logic [31:0] evt_unmask_bits;
    logic [31:0] rise_trig_en;
    logic [31:0] fall_trig_en;
    logic [31:0] sw_line_trig;
    logic [31:0] pend;
    // Registered bus and event outputs.
    logic [31:0] rdata;
    logic [31:0] evt;
  } state_s;

  state_s cur;
  state_s nxt;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res & LINE_MASK;
  endfunction : merge_strb

  function automatic logic [31:0] strb_bits(
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res & LINE_MASK;
  endfunction : strb_bits

  function automatic logic addr_mapped(
    input logic [7:0] addr
  );
    logic hit;
    unique case (addr)
      OFS_IRQ_UNMASK,
      OFS_EVT_UNMASK,
      OFS_RISE_SEL,
      OFS_FALL_SEL,
      OFS_SW_TRIG,
      OFS_PENDING:    hit = 1'b1;
      default:        hit = 1'b0;
    endcase
    return hit;
  endfunction : addr_mapped

  // A line that changes every cycle never settles, so it can never raise an edge.
  function automatic logic [31:0] filter_step(
    input logic [31:0] stage2,
    input logic [31:0] stage3,
    input logic [31:0] filt_now
  );
    logic [31:0] res;
    res = filt_now;
    for (int i = 0; i < 32; i++) begin
      if (stage2[i] == stage3[i]) begin
        res[i] = stage2[i];
      end
    end
    return res;
  endfunction : filter_step

  function automatic logic [31:0] read_word(
    input state_s     regs,
    input logic [7:0] addr
  );
    logic [31:0] res;
    unique case (addr)
      OFS_IRQ_UNMASK: res = regs.irq_unmask_bits;
      OFS_EVT_UNMASK: res = regs.evt_unmask_bits;
      OFS_RISE_SEL:   res = regs.rise_trig_en;
      OFS_FALL_SEL:   res = regs.fall_trig_en;
      OFS_SW_TRIG:    res = regs.sw_line_trig;
      OFS_PENDING:    res = regs.pend;
      default:        res = 32'h0000_0000;
    endcase
    return res;
  endfunction : read_word

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic        setup_ph;
  logic        access_ph;
  logic        wr_ok;
  logic        wr_irqm;
  logic        wr_evtm;
  logic        wr_rise;
  logic        wr_fall;
  logic        wr_sw;
  logic        wr_pend;
  logic [31:0] wbits;
  logic [31:0] line_in32;
  logic [31:0] rise_edge;
  logic [31:0] fall_edge;
  logic [31:0] hw_trig;
  logic [31:0] sw_set;
  logic [31:0] pend_clr;
  logic [31:0] polarity_chg;
  logic [31:0] irq_lines;
  logic [31:0] new_filt;
  logic [31:0] irqm_merged;
  logic [31:0] evtm_merged;
  logic [31:0] rise_merged;
  logic [31:0] fall_merged;
  logic [31:0] pend_w1c;
  logic [31:0] trig_all;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  // Zero wait states: read data is captured in the setup cycle, so it comes from a flop.
  assign pready    = 1'b1;
  // An unmapped address answers with an error and changes nothing.
  assign pslverr   = access_ph && !addr_mapped(paddr);

  // ****************************************************************
  // Write strobes
  // ****************************************************************
  assign wr_ok     = access_ph && pwrite && addr_mapped(paddr);
  assign wr_irqm   = wr_ok && (paddr == OFS_IRQ_UNMASK);
  assign wr_evtm   = wr_ok && (paddr == OFS_EVT_UNMASK);
  assign wr_rise   = wr_ok && (paddr == OFS_RISE_SEL);
  assign wr_fall   = wr_ok && (paddr == OFS_FALL_SEL);
  assign wr_sw     = wr_ok && (paddr == OFS_SW_TRIG);
  assign wr_pend   = wr_ok && (paddr == OFS_PENDING);
  assign wbits     = strb_bits(pwdata, pstrb);
  // Line 25 has no logic behind it; its bit passes the synchroniser but is masked off from the edge detectors on.
  assign line_in32 = {{(32-NUM_LINES){1'b0}}, ext_line_in};

  // ****************************************************************
  // Write data
  // ****************************************************************
  // Merged values are masked, so a careless write cannot set a reserved bit.
  assign irqm_merged = merge_strb(cur.irq_unmask_bits, pwdata, pstrb);
  assign evtm_merged = merge_strb(cur.evt_unmask_bits, pwdata, pstrb);
  assign rise_merged = merge_strb(cur.rise_trig_en, pwdata, pstrb);  // [R03]
  assign fall_merged = merge_strb(cur.fall_trig_en, pwdata, pstrb);  // [R03]
  // Writing one clears a flag; writing zero leaves it alone.
  assign pend_w1c    = wr_pend ? wbits : 32'h0000_0000;

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  always_comb begin
    // A change counts only once the two later stages agree.
    new_filt  = filter_step(cur.sync2, cur.sync3, cur.filt);
    rise_edge = new_filt & ~cur.filt & LINE_MASK;
    fall_edge = ~new_filt & cur.filt & LINE_MASK;
  end

  // Either enable alone picks its edge; both together give either edge.
  assign hw_trig = (rise_edge & cur.rise_trig_en) |   // [R01] [R12]
                   (fall_edge & cur.fall_trig_en);    // [R02] [R12]

  // ****************************************************************
  // Software trigger
  // ****************************************************************
  // A software trigger acts only on lines whose bit still reads zero.
  assign sw_set   = wr_sw ? (wbits & ~cur.sw_line_trig) : 32'h0000_0000;  // [R05]
  assign trig_all = hw_trig | sw_set;

  // ****************************************************************
  // Pending clear
  // ****************************************************************
  // A toggled enable bit, in either direction, counts as a polarity change.
  assign polarity_chg = (wr_rise ? (rise_merged ^ cur.rise_trig_en) : 32'h0000_0000) |
                        (wr_fall ? (fall_merged ^ cur.fall_trig_en) : 32'h0000_0000);
  assign pend_clr     = pend_w1c | polarity_chg;  // [R09]

  // ****************************************************************
  // Interrupt output
  // ****************************************************************
  // Lines set by software also need the event mask to pass.
  // The request is a level and drops only when the flag clears, its mask closes, or the line's software bit is set while its event mask is closed.
  assign irq_lines = cur.pend & cur.irq_unmask_bits &                   // [R10]
                     (~cur.sw_line_trig | cur.evt_unmask_bits);         // [R06]
  assign irq       = |irq_lines;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt       = cur;
    nxt.sync1 = line_in32;
    nxt.sync2 = cur.sync1;
    nxt.sync3 = cur.sync2;
    nxt.filt  = new_filt;

    if (wr_irqm) begin
      nxt.irq_unmask_bits = irqm_merged;
    end
    if (wr_evtm) begin
      nxt.evt_unmask_bits = evtm_merged;
    end
    if (wr_rise) begin
      nxt.rise_trig_en = rise_merged;  // [R03]
    end
    if (wr_fall) begin
      nxt.fall_trig_en = fall_merged;  // [R03]
    end

    // Set wins over clear, so an edge in the clearing cycle is kept.
    nxt.pend = ((cur.pend & ~pend_clr) | trig_all) & LINE_MASK;  // [R08] [R09]

    // Only a pending clear drops the software bit; writing it again does nothing.
    nxt.sw_line_trig = ((cur.sw_line_trig & ~pend_w1c) |  // [R07]
                        sw_set) & LINE_MASK;               // [R05]

    // One cycle event pulse per triggered line that the event mask passes.
    nxt.evt = trig_all & cur.evt_unmask_bits;  // [R11]

    // Taking read data in the setup cycle lets prdata come from a flop with no wait state.
    if (setup_ph && !pwrite) begin
      nxt.rdata = read_word(cur, paddr);
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Every field resets to a constant; the synchroniser starts at the idle low level.
      cur.sync1           <= 32'h0000_0000;
      cur.sync2           <= 32'h0000_0000;
      cur.sync3           <= 32'h0000_0000;
      cur.filt            <= 32'h0000_0000;
      cur.irq_unmask_bits <= RST_IRQ_MASK;
      cur.evt_unmask_bits <= RST_EVT_MASK;
      cur.rise_trig_en    <= RST_RISE_SEL;
      cur.fall_trig_en    <= RST_FALL_SEL;  // [R04]
      cur.sw_line_trig    <= RST_SW_TRIG;
      cur.pend            <= RST_PENDING;
      cur.rdata           <= RST_RDATA;
      cur.evt             <= 32'h0000_0000;
    end else begin
      cur <= nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata             = cur.rdata;
  assign evt_out            = cur.evt[NUM_LINES-1:0];
  assign line_pending_flags = cur.pend[NUM_LINES-1:0];

endmodule : ext_line_edge_trigger_cfg

`default_nettype wire

// *** ext_line_edge_trigger_cfg_props.sv ***
// Port checks for the external line edge trigger front end.
`timescale 1ns/10ps
`default_nettype none
module ext_line_edge_trigger_cfg_props
  import ext_line_ctrl_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [NUM_LINES-1:0] evt_out,
  input wire logic [NUM_LINES-1:0] line_pending_flags,
  input wire logic                 irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc_wr;
  assign acc_wr = psel & penable & pwrite;
  a_ready_high: assert property (pready) else $error("pready low");
  a_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("no slave error");
  a_irq_needs_pend: assert property (irq |-> line_pending_flags != '0)
    else $error("irq without pending");
  a_evt_sets_pend: assert property ((evt_out & ~line_pending_flags) == '0)
    else $error("event without pending");
  a_evt_one_cycle: assert property ((evt_out & $past(evt_out)) == '0)
    else $error("event longer than a cycle");
  a_pend_fall_cause: assert property ($fell(line_pending_flags[0]) |-> $past(acc_wr))
    else $error("pending cleared without a write");
  a_sw_sets_pend: assert property (acc_wr && paddr == OFS_SW_TRIG && pwdata[1] && pstrb[0]
    |=> line_pending_flags[1]) else $error("sw trigger lost");
  a_gap_line_idle: assert property (!line_pending_flags[25] && !evt_out[25])
    else $error("line 25 active");
endmodule : ext_line_edge_trigger_cfg_props
bind ext_line_edge_trigger_cfg ext_line_edge_trigger_cfg_props u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .pslverr, .evt_out,
  .line_pending_flags, .irq);
`default_nettype wire

// *** ext_line_src.sv ***
// Model of the external lines feeding the trigger front end.
`timescale 1ns/10ps
`default_nettype none
module ext_line_src
  import ext_line_ctrl_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [NUM_LINES-1:0] lvl,
  output var  logic [NUM_LINES-1:0] ext_line_in
);
  // Line 25 has no trigger logic, so it toggles every cycle to show it is ignored.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ext_line_in <= '0;
    else ext_line_in <= {lvl[26], ~ext_line_in[25], lvl[24:0]};
  end
endmodule : ext_line_src
`default_nettype wire

// *** ext_line_edge_trigger_cfg_bench.sv ***
// Self-checking bench for the external line edge trigger front end.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g,e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ext_line_edge_trigger_cfg_bench
  import ext_line_ctrl_pkg::*;
;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]           paddr;
  logic [31:0]          pwdata, prdata, rv;
  logic [3:0]           pstrb;
  logic [NUM_LINES-1:0] lvl, ext_line_in, evt_out, line_pending_flags, seen;
  int                   num_errors, checks_done, cyc;
  ext_line_edge_trigger_cfg dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ext_line_in, .evt_out, .line_pending_flags, .irq);
  ext_line_src lines (.pclk, .presetn, .lvl, .ext_line_in);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Events last one cycle, so they are gathered here and compared later.
  always @(posedge pclk) begin
    seen <= seen | evt_out;
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(rv, e)
  endtask : rd
  // Lines settle through the input synchroniser before the pending flags are compared.
  task automatic step(input logic [NUM_LINES-1:0] v, input logic [NUM_LINES-1:0] e);
    lvl <= v;
    repeat (8) @(posedge pclk);
    `CHK(line_pending_flags, e)
  endtask : step
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    lvl = '0;
    seen = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_FALL_SEL, RST_FALL_SEL);
    rd(OFS_SW_TRIG, RST_SW_TRIG);
    xfer(1'b0, 8'h20, 32'h0000_0000);
    `CHK({er, rv}, 33'h1_0000_0000)
    xfer(1'b1, OFS_FALL_SEL, LINE_MASK);
    rd(OFS_FALL_SEL, LINE_MASK);
    $display("registers done");
    xfer(1'b1, OFS_FALL_SEL, 32'h0000_0006);
    xfer(1'b1, OFS_RISE_SEL, 32'h0000_0005);
    xfer(1'b1, OFS_IRQ_UNMASK, 32'h0000_000f);
    xfer(1'b1, OFS_EVT_UNMASK, 32'h0000_0001);
    step(27'h000_000f, 27'h000_0005);
    `CHK({irq, seen}, {1'b1, 27'h000_0001})
    xfer(1'b1, OFS_PENDING, 32'h0000_000f);
    `CHK({irq, line_pending_flags}, 28'h000_0000)
    step(27'h000_0000, 27'h000_0006);
    xfer(1'b1, OFS_IRQ_UNMASK, 32'h0000_0000);
    `CHK(irq, 1'b0)
    xfer(1'b1, OFS_RISE_SEL, 32'h0000_0001);
    `CHK(line_pending_flags, 27'h000_0002)
    $display("edges done");
    xfer(1'b1, OFS_PENDING, 32'h07ff_ffff);
    xfer(1'b1, OFS_IRQ_UNMASK, 32'h0000_0002);
    xfer(1'b1, OFS_SW_TRIG, 32'h0000_0002);
    rd(OFS_SW_TRIG, 32'h0000_0002);
    `CHK({irq, line_pending_flags}, 28'h000_0002)
    xfer(1'b1, OFS_EVT_UNMASK, 32'h0000_0003);
    `CHK(irq, 1'b1)
    xfer(1'b1, OFS_SW_TRIG, 32'h0000_0002);
    rd(OFS_SW_TRIG, 32'h0000_0002);
    xfer(1'b1, OFS_PENDING, 32'h0000_0002);
    rd(OFS_SW_TRIG, 32'h0000_0000);
    `CHK({irq, line_pending_flags}, 28'h000_0000)
    $display("software trigger done");
    pstrb <= 4'h1;
    xfer(1'b1, OFS_RISE_SEL, 32'h0000_0f0e);
    pstrb <= 4'hf;
    rd(OFS_RISE_SEL, 32'h0000_000e);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_FALL_SEL, RST_FALL_SEL);
    $display("strobe and reset done");
    tally_and_finish();
  end
endmodule : ext_line_edge_trigger_cfg_bench
`default_nettype wire
